/* File: queued_spi_master_control.sv */
`timescale 1ns/1ps
`include "queued_spi_regs.svh"

module queued_spi_master_control #(
   parameter int TRAIL_ZERO_CYCLES = `QS_TRAIL_ZERO_CYC
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_b_i,
   // Register port
   input  wire logic [11:0] reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [15:0] reg_wdata_i,
   output logic      [15:0] reg_rdata_o,
   // Loose control and status
   input  wire logic        abort_lockout_i,
   input  wire logic        queue_finished_clear_i,
   output logic             queue_finished_o,
   // Command entry of the current pointer
   output logic      [3:0]  cmd_ptr_o,
   input  wire logic [3:0]  cmd_select_i,
   input  wire logic        cmd_clock_delay_en_i,
   input  wire logic        cmd_after_delay_en_i,
   input  wire logic        cmd_width_en_i,
   // Transmit stream in, receive words out
   input  wire logic [15:0] tx_data_i,
   input  wire logic        tx_valid_i,
   output logic             tx_ready_o,
   output logic      [15:0] rx_data_o,
   output logic             rx_valid_o,
   // Serial pins
   output logic             sck_o,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   input  wire logic        miso_i,
   output logic      [3:0]  cs_o
);
   queued_spi_pkg::engine_state_t state_reg;
   logic [15:0] mode_reg;
   logic        run_en_reg;
   logic [6:0]  lead_dly_reg;
   logic [7:0]  trail_dly_reg;
   logic        halt_reg;
   logic        loop_en_reg;
   logic        loop_to_start_reg;
   logic        sel_idle_reg;
   logic [3:0]  end_ptr_reg;
   logic [3:0]  done_ptr_reg;
   logic [3:0]  start_ptr_reg;
   logic        start_fresh_reg;
   logic        finished_reg;
   logic [3:0]  sel_reg;
   logic        trail_prog_reg;
   logic [4:0]  nbits_reg;
   logic [13:0] dly_cnt_reg;
   logic [7:0]  half_cnt_reg;
   logic [4:0]  edge_cnt_reg;
   logic [15:0] tx_shift_reg;
   logic [15:0] rx_shift_reg;
   logic        miso_meta_reg;
   logic        miso_sync_reg;
   logic [15:0] fifo_data;
   logic        fifo_valid;
   logic        fifo_pop;
   logic [7:0]  baud;
   logic        clock_idle_level;
   logic        clock_sample_phase;
   logic        wr_mode;
   logic        wr_delay;
   logic        wr_wrap;
   logic        at_edge;
   logic        last_edge;
   logic        leading;
   logic        entry_done;
   logic        at_end;
   logic        start_go;
   logic        abort_wr;
   logic [4:0]  width_sel;
   logic [13:0] lead_len;
   logic [13:0] trail_len;

   assign baud     = mode_reg[`QS_MODE_BAUD_HI:`QS_MODE_BAUD_LO];
   assign clock_idle_level     = mode_reg[`QS_MODE_CLOCK_IDLE_LEVEL_BIT];
   assign clock_sample_phase     = mode_reg[`QS_MODE_CLOCK_SAMPLE_PHASE_BIT];
   assign wr_mode  = reg_wr_i && (reg_addr_i == `QS_MODE_OFS);
   assign wr_delay = reg_wr_i && (reg_addr_i == `QS_DELAY_OFS);
   assign wr_wrap  = reg_wr_i && (reg_addr_i == `QS_WRAP_OFS);

   // Transmit words wait here; the engine stalls on an empty queue
   word_fifo #(.WIDTH(16), .DEPTH(16)) tx_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_b_i     (rst_b_i),
      .in_data_i   (tx_data_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // Decoded engine events
   assign fifo_pop   = (state_reg == queued_spi_pkg::st_load) && fifo_valid;
   assign at_edge    = (state_reg == queued_spi_pkg::st_shift) && (half_cnt_reg == 8'h01);
   assign leading    = !edge_cnt_reg[0];
   assign last_edge  = at_edge && ((edge_cnt_reg + 5'h01) == {nbits_reg[3:0], 1'b0});
   assign entry_done = (state_reg == queued_spi_pkg::st_trail) && (dly_cnt_reg == 14'h0001);
   assign at_end     = (cmd_ptr_o == end_ptr_reg);
   assign start_go   = (state_reg == queued_spi_pkg::st_idle) && run_en_reg && !halt_reg && (baud != 8'h00);
   assign abort_wr   = wr_delay && !reg_wdata_i[`QS_DLY_ENABLE_BIT] && run_en_reg && !abort_lockout_i;

   // Width per entry; reserved codes fall back to 16 bits
   always_comb
   begin
      width_sel = `QS_DEFAULT_BITS;
      if (cmd_width_en_i)
         width_sel = mode_reg[`QS_MODE_WIDTH_HI] ? {2'b01, mode_reg[`QS_MODE_WIDTH_LO+2:`QS_MODE_WIDTH_LO]}
                                                  : `QS_FULL_BITS;
   end

   // Lead and trail lengths in system clocks
   always_comb
   begin
      lead_len = {6'h00, baud};
      if (cmd_clock_delay_en_i && (lead_dly_reg != 7'h00))
         lead_len = {7'h00, lead_dly_reg};
      trail_len = `QS_STD_AFTER_CYC;
      if (trail_prog_reg)
         trail_len = (trail_dly_reg == 8'h00) ? 14'(TRAIL_ZERO_CYCLES)
                                              : {1'b0, trail_dly_reg, 5'h00};
   end

   // Two-stage synchroniser on the data input pin
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         miso_meta_reg <= 1'b0;
         miso_sync_reg <= 1'b0;
      end
      else
      begin
         miso_meta_reg <= miso_i;
         miso_sync_reg <= miso_meta_reg;
      end
   end

   // Mode register; master bit only stored, software keeps it set
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         mode_reg <= `QS_MODE_RST;
      else if (wr_mode)
         mode_reg <= reg_wdata_i;
   end

   // Delay fields
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         lead_dly_reg  <= 7'(`QS_DELAY_RST >> `QS_DLY_LEAD_LO);
         trail_dly_reg <= 8'(`QS_DELAY_RST);
      end
      else if (wr_delay)
      begin
         lead_dly_reg  <= reg_wdata_i[`QS_DLY_LEAD_HI:`QS_DLY_LEAD_LO];
         trail_dly_reg <= reg_wdata_i[`QS_DLY_TRAIL_HI:`QS_DLY_TRAIL_LO];
      end
   end

   // Enable bit: software sets, hardware or an unlocked write clears
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         run_en_reg <= 1'b0;
      else if (wr_delay && reg_wdata_i[`QS_DLY_ENABLE_BIT])
         run_en_reg <= 1'b1;
      else if (abort_wr)
         run_en_reg <= 1'b0;
      else if (entry_done && (halt_reg || (at_end && !loop_en_reg)))
         run_en_reg <= 1'b0;
      else if (baud == 8'h00)
         run_en_reg <= run_en_reg;
   end

   // Wrap register; completed pointer is not writable
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         halt_reg  <= 1'b0;
         loop_en_reg       <= 1'b0;
         loop_to_start_reg <= 1'b0;
         sel_idle_reg      <= 1'b0;
         end_ptr_reg       <= 4'h0;
         start_ptr_reg     <= 4'h0;
      end
      else if (wr_wrap)
      begin
         halt_reg          <= reg_wdata_i[`QS_WRAP_HALT_BIT];
         loop_en_reg       <= reg_wdata_i[`QS_WRAP_LOOP_BIT];
         loop_to_start_reg <= reg_wdata_i[`QS_WRAP_TARGET_BIT];
         sel_idle_reg      <= reg_wdata_i[`QS_WRAP_IDLE_BIT];
         end_ptr_reg       <= reg_wdata_i[`QS_WRAP_END_HI:`QS_WRAP_END_LO];
         start_ptr_reg     <= reg_wdata_i[`QS_WRAP_NEW_HI:`QS_WRAP_NEW_LO];
      end
   end

   // A pointer written mid-run redirects the next command
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         start_fresh_reg <= 1'b0;
      else if (wr_wrap && (state_reg != queued_spi_pkg::st_idle))
         start_fresh_reg <= 1'b1;
      else if (entry_done || state_reg == queued_spi_pkg::st_idle)
         start_fresh_reg <= 1'b0;
   end

   // Finished flag; a set in the clearing cycle wins
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         finished_reg <= 1'b0;
      else if (entry_done && (at_end || halt_reg))
         finished_reg <= 1'b1;
      else if (queue_finished_clear_i)
         finished_reg <= 1'b0;
   end
   assign queue_finished_o = finished_reg;

   // Queue pointer and completed pointer
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         cmd_ptr_o <= 4'h0;
         done_ptr_reg <= 4'h0;
      end
      else if (start_go)
         cmd_ptr_o <= start_ptr_reg;
      else if (entry_done)
      begin
         done_ptr_reg <= cmd_ptr_o;
         if (start_fresh_reg)
            cmd_ptr_o <= start_ptr_reg;
         else if (at_end)
            cmd_ptr_o <= loop_to_start_reg ? start_ptr_reg : 4'h0;
         else
            cmd_ptr_o <= cmd_ptr_o + 4'h1;
      end
   end

   // Sequencer: load, lead delay, shift, trail delay
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i || baud == 8'h00 || abort_wr)
         state_reg <= queued_spi_pkg::st_idle;
      else
      begin
         unique case (state_reg)
            queued_spi_pkg::st_idle:
               if (start_go)
                  state_reg <= queued_spi_pkg::st_load;
            queued_spi_pkg::st_load:
               if (fifo_valid)
                  state_reg <= queued_spi_pkg::st_lead;
            queued_spi_pkg::st_lead:
               if (dly_cnt_reg == 14'h0001)
                  state_reg <= queued_spi_pkg::st_shift;
            queued_spi_pkg::st_shift:
               if (last_edge)
                  state_reg <= queued_spi_pkg::st_trail;
            queued_spi_pkg::st_trail:
               if (entry_done)
                  state_reg <= (halt_reg || (at_end && !loop_en_reg)) ? queued_spi_pkg::st_idle
                                                                    : queued_spi_pkg::st_load;
         endcase
      end
   end

   // Per-entry command latch and delay counter
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         sel_reg     <= 4'h0;
         trail_prog_reg <= 1'b0;
         nbits_reg   <= `QS_DEFAULT_BITS;
         dly_cnt_reg <= 14'h0000;
      end
      else if (fifo_pop)
      begin
         sel_reg     <= cmd_select_i;
         trail_prog_reg <= cmd_after_delay_en_i;
         nbits_reg   <= width_sel;
         dly_cnt_reg <= lead_len;
      end
      else if (last_edge)
         dly_cnt_reg <= trail_len;
      else if (dly_cnt_reg != 14'h0000)
         dly_cnt_reg <= dly_cnt_reg - 14'h0001;
   end

   // Half-period timer; a full clock spans twice the divider
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         half_cnt_reg <= 8'h00;
         edge_cnt_reg <= 5'h00;
      end
      else if (state_reg != queued_spi_pkg::st_shift)
      begin
         half_cnt_reg <= baud;
         edge_cnt_reg <= 5'h00;
      end
      else if (at_edge)
      begin
         half_cnt_reg <= baud;
         edge_cnt_reg <= edge_cnt_reg + 5'h01;
      end
      else
         half_cnt_reg <= half_cnt_reg - 8'h01;
   end

   // Clock pin toggles per edge and rests at the polarity level
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         sck_o <= 1'b0;
      else if (state_reg != queued_spi_pkg::st_shift)
         sck_o <= clock_idle_level;
      else if (at_edge)
         sck_o <= !sck_o;
   end

   // Shifters; sampled input lags two clocks behind the pin
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         tx_shift_reg <= 16'h0000;
         rx_shift_reg <= 16'h0000;
      end
      else if (fifo_pop)
         tx_shift_reg <= fifo_data << (5'h10 - width_sel);
      else if (at_edge)
      begin
         if (leading != clock_sample_phase)
            rx_shift_reg <= {rx_shift_reg[14:0], miso_sync_reg};
         else if (!(clock_sample_phase && edge_cnt_reg == 5'h00))
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
      end
   end

   // Received word, right aligned, pulsed once per entry
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         rx_data_o  <= 16'h0000;
         rx_valid_o <= 1'b0;
      end
      else
      begin
         rx_valid_o <= last_edge;
         if (last_edge)
            rx_data_o <= (clock_sample_phase ? {rx_shift_reg[14:0], miso_sync_reg} : rx_shift_reg)
                         & ~(16'hFFFF << nbits_reg); // Older bits masked off
      end
   end

   // Data and select pins
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         mosi_o    <= 1'b0;
         mosi_oe_o <= 1'b1;
         cs_o      <= 4'h0;
      end
      else
      begin
         mosi_o    <= tx_shift_reg[15];
         mosi_oe_o <= !mode_reg[`QS_MODE_FLOAT_BIT] || (state_reg == queued_spi_pkg::st_lead)
                      || (state_reg == queued_spi_pkg::st_shift);
         cs_o      <= ((state_reg == queued_spi_pkg::st_lead) || (state_reg == queued_spi_pkg::st_shift))
                      ? sel_reg : {4{sel_idle_reg}};
      end
   end

   // Registered read port; unmapped offsets read zero
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
         reg_rdata_o <= 16'h0000;
      else if (reg_rd_i)
         unique case (reg_addr_i)
            `QS_MODE_OFS:  reg_rdata_o <= mode_reg;
            `QS_DELAY_OFS: reg_rdata_o <= {run_en_reg, lead_dly_reg, trail_dly_reg};
            `QS_WRAP_OFS:  reg_rdata_o <= {halt_reg, loop_en_reg, loop_to_start_reg, sel_idle_reg,
                                           end_ptr_reg, done_ptr_reg, start_ptr_reg};
            default:       reg_rdata_o <= 16'h0000;
         endcase
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   a_clock_idle_level: assert property ((state_reg != queued_spi_pkg::st_shift) |=> sck_o == $past(clock_idle_level))
      else $error("serial clock not at idle level");
   a_float_between: assert property ((state_reg == queued_spi_pkg::st_idle && mode_reg[14]) |=> !mosi_oe_o)
      else $error("data output driven while float enabled");
   a_drive_between: assert property (!mode_reg[14] |=> mosi_oe_o)
      else $error("data output floated while drive selected");
   a_select_idle: assert property ((state_reg == queued_spi_pkg::st_idle) |=> cs_o == {4{$past(sel_idle_reg)}})
      else $error("selects not at idle level");
   a_zero_divider: assert property ((baud == 8'h00) |=> state_reg == queued_spi_pkg::st_idle)
      else $error("engine running with zero divider");
   a_start_pointer: assert property (start_go |=> cmd_ptr_o == $past(start_ptr_reg))
      else $error("queue did not start at start pointer");
   a_std_pause: assert property ((last_edge && !trail_prog_reg && !abort_wr && baud != 8'h00 && !wr_delay
                                  && !wr_mode) |=> ##16 entry_done)
      else $error("standard pause not 17 clocks");
   a_end_stop: assert property ((entry_done && at_end && !loop_en_reg && !wr_delay)
                                |=> !run_en_reg && finished_reg && state_reg == queued_spi_pkg::st_idle)
      else $error("queue end did not stop engine");
   a_halt_stop: assert property ((entry_done && halt_reg && !wr_delay)
                                 |=> !run_en_reg ##0 state_reg == queued_spi_pkg::st_idle)
      else $error("halt did not stop after command");
   a_completed_ptr: assert property (entry_done |=> done_ptr_reg == $past(cmd_ptr_o))
      else $error("completed pointer not updated");

   c_wrap: cover property (entry_done && at_end && loop_en_reg);
   c_halt: cover property (entry_done && halt_reg);
   c_abort: cover property (abort_wr && state_reg == queued_spi_pkg::st_shift);
   c_long_pause: cover property (last_edge && trail_prog_reg && trail_dly_reg == 8'h00);
endmodule // queued_spi_master_control

/* File: queued_spi_regs.svh */
`ifndef QUEUED_SPI_REGS_SVH
`define QUEUED_SPI_REGS_SVH

// Register byte offsets
`define QS_MODE_OFS         12'h340
`define QS_DELAY_OFS        12'h344
`define QS_WRAP_OFS         12'h348

// Mode register fields
`define QS_MODE_MASTER_BIT  15
`define QS_MODE_FLOAT_BIT   14
`define QS_MODE_WIDTH_HI    13
`define QS_MODE_WIDTH_LO    10
`define QS_MODE_CLOCK_IDLE_LEVEL_BIT    9
`define QS_MODE_CLOCK_SAMPLE_PHASE_BIT    8
`define QS_MODE_BAUD_HI     7
`define QS_MODE_BAUD_LO     0

// Enable and delay register fields
`define QS_DLY_ENABLE_BIT   15
`define QS_DLY_LEAD_HI      14
`define QS_DLY_LEAD_LO      8
`define QS_DLY_TRAIL_HI     7
`define QS_DLY_TRAIL_LO     0

// Wrap register fields
`define QS_WRAP_HALT_BIT    15
`define QS_WRAP_LOOP_BIT    14
`define QS_WRAP_TARGET_BIT  13
`define QS_WRAP_IDLE_BIT    12
`define QS_WRAP_END_HI      11
`define QS_WRAP_END_LO      8
`define QS_WRAP_CPT_HI      7
`define QS_WRAP_CPT_LO      4
`define QS_WRAP_NEW_HI      3
`define QS_WRAP_NEW_LO      0

// Reset values
`define QS_MODE_RST         16'h8104
`define QS_DELAY_RST        16'h0404
`define QS_WRAP_RST         16'h0000

// Timing counts in system clocks, trail scale shift, and transfer widths in bits
`define QS_STD_AFTER_CYC    14'h0011
`define QS_TRAIL_SCALE_SHIFT 5
`define QS_TRAIL_ZERO_CYC   8192
`define QS_DEFAULT_BITS     5'h08
`define QS_FULL_BITS        5'h10

`endif

/* File: queued_spi_pkg.sv */
package queued_spi_pkg;
   typedef enum logic [2:0] {st_idle, st_load, st_lead, st_shift, st_trail} engine_state_t;
endpackage

/* File: word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_b_i,
   // Filling side
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   // Draining side
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // Honest flags straight from the fill count
   assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign out_data_o  = mem[rd_ptr_reg];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Storage array, no reset needed on data
   always_ff @(posedge clk_sys_i)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_data_i;
   end

   // Pointers and fill count
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule // word_fifo

/* File: spi_peripheral_model.sv */
`timescale 1ns/1ps
module spi_peripheral_model #(
   parameter logic [7:0] REPLY = 8'hA5
) (
   // Serial pins
   input  wire logic       sck_i,
   input  wire logic       sel_i,
   input  wire logic       mosi_i,
   output logic            miso_o,
   // Captured byte
   output logic      [7:0] got_o
);
   int unsigned idx = 0;

   // Capture on the leading edge, mode zero
   always @(posedge sck_i)
      if (sel_i) got_o <= {got_o[6:0], mosi_i};

   // Advance reply bit on trailing edge, restart on deselect
   always @(negedge sck_i or negedge sel_i)
      if (!sel_i) idx <= 0;
      else idx <= idx + 1;

   // Released line shows the inverse, so a late sample cannot pass by luck
   always_comb miso_o = sel_i ? REPLY[3'h7 - idx[2:0]] : ~REPLY[0];
endmodule // spi_peripheral_model

/* File: queued_spi_master_control_tb_top.sv */
`timescale 1ns/1ps
module queued_spi_master_control_tb_top;
   typedef struct packed {logic [11:0] a; logic w; logic [15:0] d; logic [15:0] e;} row_t;
   logic        clk_sys_i    = 1'b0;
   logic        rst_b_i      = 1'b0;
   logic [11:0] reg_addr_i   = 12'h000;
   logic        reg_wr_i     = 1'b0;
   logic        reg_rd_i     = 1'b0;
   logic [15:0] reg_wdata_i  = 16'h0000;
   logic [15:0] tx_data_i    = 16'h0000;
   logic        tx_valid_i   = 1'b0;
   logic [3:0]  cmd_select_i = 4'h1;
   logic        cmd_width_en_i = 1'b0;
   logic        cmd_clock_delay_en_i   = 1'b0;
   logic        cmd_after_delay_en_i   = 1'b0;
   logic        queue_finished_clear_i = 1'b0;
   logic [15:0] reg_rdata_o, rx_data_o, rd_val;
   logic        tx_ready_o, rx_valid_o, sck_o, mosi_o, mosi_oe_o, miso_i, queue_finished_o, prev;
   logic [3:0]  cs_o, cmd_ptr_o;
   logic [7:0]  got;
   int          error_cnt = 0;
   int          n_tests   = 0;
   int          edges     = 0;
   int          highs     = 0;
   logic        seen_sel  = 1'b0;
   row_t rows [6] = '{'{12'h340, 1'b0, 16'h0000, 16'h8104}, '{12'h344, 1'b0, 16'h0000, 16'h0404},
      '{12'h348, 1'b0, 16'h0000, 16'h0000}, '{12'h34C, 1'b0, 16'h0000, 16'h0000},
      '{12'h348, 1'b1, 16'h02F2, 16'h0202}, '{12'h340, 1'b1, 16'hA204, 16'hA204}};

   queued_spi_master_control #(.TRAIL_ZERO_CYCLES(64)) u_queued_spi_master_control (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .abort_lockout_i(1'b0),
      .queue_finished_clear_i(queue_finished_clear_i), .queue_finished_o(queue_finished_o), .cmd_ptr_o(cmd_ptr_o),
      .cmd_select_i(cmd_select_i), .cmd_clock_delay_en_i(cmd_clock_delay_en_i),
      .cmd_after_delay_en_i(cmd_after_delay_en_i),
      .cmd_width_en_i(cmd_width_en_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
      .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .sck_o(sck_o),
      .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_i), .cs_o(cs_o));

   spi_peripheral_model u_spi_peripheral_model (
      .sck_i(sck_o), .sel_i(cs_o[0]), .mosi_i(mosi_o), .miso_o(miso_i), .got_o(got));

   // System clock, 100 MHz
   always #5 clk_sys_i = ~clk_sys_i;

   // Compare one value
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Register write, one strobe cycle
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask

   // Register read, data taken once settled
   task automatic rd(input logic [11:0] a);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      @(negedge clk_sys_i);
      rd_val = reg_rdata_o;
   endtask

   // Verdict and end of run
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog, run needs a few hundred cycles
   initial
   begin
      #100000;
      error_cnt++;
      test_done();
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk(rd_val, rows[i].e);
      end
      // Idle pins with polarity one, data driven
      repeat (3) @(negedge clk_sys_i);
      chk({15'h0000, sck_o}, 16'h0001);
      chk({15'h0000, mosi_oe_o}, 16'h0001);
      wr(12'h340, 16'hC004);
      repeat (3) @(negedge clk_sys_i);
      chk({15'h0000, sck_o}, 16'h0000);
      chk({15'h0000, mosi_oe_o}, 16'h0000);
      // One 8-bit entry, divider 4, entry 2 is both start and end
      wr(12'h340, 16'h8004);
      @(posedge clk_sys_i);
      tx_data_i  <= 16'h005A;
      tx_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      tx_valid_i <= 1'b0;
      wr(12'h344, 16'h8404);
      prev = sck_o;
      for (int k = 0; k < 3000 && rx_valid_o !== 1'b1; k++)
      begin
         @(negedge clk_sys_i);
         if (sck_o !== prev) edges++;
         highs += int'(sck_o);
         if (cs_o === 4'h1) seen_sel = 1'b1;
         prev = sck_o;
      end
      chk(rx_data_o, 16'h00A5);
      chk({8'h00, got}, 16'h005A);
      chk(16'(edges), 16'h0010);
      chk(16'(highs), 16'h0020);
      chk({15'h0000, seen_sel}, 16'h0001);
      // Trail of 17 clocks, then the queue stops
      repeat (40) @(negedge clk_sys_i);
      chk({12'h000, cs_o}, 16'h0000);
      chk({15'h0000, queue_finished_o}, 16'h0001);
      rd(12'h344);
      chk(rd_val, 16'h0404);
      rd(12'h348);
      chk(rd_val, 16'h0222);
      // Programmed lead of 6 and pause of 32; flag cleared first
      @(posedge clk_sys_i);
      queue_finished_clear_i <= 1'b1;
      cmd_clock_delay_en_i   <= 1'b1;
      cmd_after_delay_en_i   <= 1'b1;
      tx_data_i              <= 16'h00C3;
      tx_valid_i             <= 1'b1;
      @(posedge clk_sys_i);
      queue_finished_clear_i <= 1'b0;
      tx_valid_i             <= 1'b0;
      wr(12'h344, 16'h8601);
      edges = 0;
      highs = 0;
      prev  = sck_o;
      for (int k = 0; k < 3000 && rx_valid_o !== 1'b1; k++)
      begin
         @(negedge clk_sys_i);
         if (cs_o === 4'h1 && sck_o === prev && edges == 0) highs++;
         if (sck_o !== prev) edges++;
         prev = sck_o;
      end
      chk(rx_data_o, 16'h00A5);
      chk({8'h00, got}, 16'h00C3);
      chk(16'(highs), 16'h0009);
      edges = 0;
      for (int k = 0; k < 3000 && queue_finished_o !== 1'b1; k++)
      begin
         @(negedge clk_sys_i);
         edges++;
      end
      chk(16'(edges), 16'h0020);
      test_done();
   end
endmodule // queued_spi_master_control_tb_top
